// file: rtl/audio_cfg_map.svh
// Register indices, field positions, reset values and code points of the
// audio configuration register bank.
// Assumes one 32-bit word per register, byte address = index * 4.
`ifndef AUDIO_CFG_MAP_SVH
`define AUDIO_CFG_MAP_SVH

// Register indices and address decode
`define IDX_W             6
`define IDX_PIN_DIR       6'h0c
`define IDX_POWER         6'h10
`define IDX_ANALOG_SEL    6'h12
`define IDX_TX_STATUS     6'h16
`define ADDR_IDX_LSB      2
`define ADDR_IDX_MSB      7
`define ADDR_TOP_LSB      8
`define HSIZE_WORD        3'h2
`define HTRANS_NONSEQ     2'h2
`define BYTE_OFS_ZERO     2'h0
`define WORD_ZERO         32'h0000_0000

// Pin direction register
`define DIR_LSB           24
`define DIR_MSB           25
`define DIR_RESET         2'h3

// Power enable register
`define PWR_TX_BIT        7
`define PWR_DAC3_BIT      6
`define PWR_DAC2_BIT      5
`define PWR_DAC1_BIT      4
`define PWR_ADC_BIT       3
`define PWR_AMP1_BIT      0

// Analog input selectors
`define SEL_HI_LSB        24
`define SEL_HI_MSB        27
`define SEL_LO_LSB        0
`define SEL_LO_MSB        3
`define SEL_MUTE          4'h0
`define SEL_DAC           4'hb
`define SEL_RSVD_FIRST    4'hc
`define SEL_RESET         4'h0

// Transmitter channel-status fields
`define TX_COPY_BIT       31
`define TX_EMPH_BIT       30
`define TX_CLOCK_ACCURACY_FIELD_LSB      28
`define TX_CLOCK_ACCURACY_FIELD_MSB      29
`define TX_WLEN_LSB       24
`define TX_WLEN_MSB       27
`define TX_RATE_LSB       22
`define TX_RATE_MSB       23
`define TX_VLEFT_BIT      21
`define TX_VRIGHT_BIT     20
`define TX_SRC_LSB        16
`define TX_SRC_MSB        19
`define TX_CAT_LSB        9
`define TX_CAT_MSB        15
`define TX_GEN_BIT        8
`define TX_ROUTE_LSB      0
`define TX_ROUTE_MSB      1

// Transmitter reset values: 24-bit words, 48 kHz, channel 2, DSP category
`define TX_WLEN_24BIT     4'h0
`define TX_RATE_48K       2'h1
`define TX_SRC_RESET      4'h2
`define TX_CAT_RESET      7'h2a
`define TX_CLOCK_ACCURACY_FIELD_RESET    2'h0

`endif

// file: rtl/audio_cfg_pkg.sv
// Types shared by the audio configuration register bank.
// Assumes the constants of audio_cfg_map.svh for widths of codes.
package audio_cfg_pkg;

	typedef logic [3:0] select_code_t;

	// Source routed to the shared serial/transmitter output pin
	typedef enum logic [1:0]
	{
		route_serial_two = 2'b00,
		route_transmitter = 2'b01,
		route_passthrough = 2'b11
	} output_route_e;

	typedef struct packed
	{
		logic       dac;
		logic [9:0] line;
		logic       mute;
	} select_dec_s;

endpackage

// file: rtl/reg_access_if.sv
// Word access path between the bus slave and the register bank.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`include "audio_cfg_map.svh"

interface reg_access_if;
	logic                wr_en;
	logic [`IDX_W-1:0]   index;
	logic [31:0]         wdata;
	logic [31:0]         rdata;

	modport bus
	(
		output wr_en,
		output index,
		output wdata,
		input  rdata
	);

	modport regs
	(
		input  wr_en,
		input  index,
		input  wdata,
		output rdata
	);
endinterface

// file: rtl/ahb_word_slave.sv
// AHB-Lite slave front end: word-only single transfers, writes with no
// wait state, reads with one wait state. Assumes one slave on the bus.
`timescale 1ns/1ps
`include "audio_cfg_map.svh"

module ahb_word_slave
(
	// Clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// AHB-Lite slave side
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic [31:0]      hrdata,
	output logic             hresp,
	// Register side
	reg_access_if.bus        ra
);

	logic                take;
	logic                legal;
	logic                wr_pend;
	logic                rd_pend;
	logic                rd_ok;
	logic [`IDX_W-1:0]   idx;

	// Only whole aligned words inside the bank window are accepted
	assign take  = hsel & htrans[1] & hready;
	assign legal = (hsize == `HSIZE_WORD)
		&& (haddr[1:0] == `BYTE_OFS_ZERO)
		&& (haddr[31:`ADDR_TOP_LSB] == '0);

	assign ra.wr_en = wr_pend;
	assign ra.index = idx;
	assign ra.wdata = hwdata;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend   <= 1'b0;
			rd_pend   <= 1'b0;
			rd_ok     <= 1'b0;
			idx       <= '0;
			hreadyout <= 1'b1;
			hrdata    <= `WORD_ZERO;
			hresp     <= 1'b0;
		end
		else
		begin
			wr_pend <= take & hwrite & legal;
			if (take)
			begin
				idx   <= haddr[`ADDR_IDX_MSB:`ADDR_IDX_LSB];
				rd_ok <= legal;
			end
			// Read waits one cycle so a write just before it is seen
			if (take & ~hwrite)
			begin
				rd_pend   <= 1'b1;
				hreadyout <= 1'b0;
			end
			else if (rd_pend)
			begin
				rd_pend   <= 1'b0;
				hreadyout <= 1'b1;
				hrdata    <= rd_ok ? ra.rdata : `WORD_ZERO;
			end
		end
	end

endmodule

// file: rtl/audio_cfg_regs.sv
// Audio configuration register bank behind an AHB-Lite slave: pin
// directions, block power enables, two analog input selectors and the
// transmitter channel-status word.
// Assumes a single AHB-Lite master and synchronous control inputs.
//
// The AHB-Lite slave port was decided locally.
`timescale 1ns/1ps
`include "audio_cfg_map.svh"

module audio_cfg_regs
#(
	parameter int PIN_COUNT  = 2,
	parameter int LINE_COUNT = 10
)
(
	// Clock and reset
	input  wire logic                    hclk,
	input  wire logic                    hresetn,
	// AHB-Lite slave
	input  wire logic                    hsel,
	input  wire logic [31:0]             haddr,
	input  wire logic [1:0]              htrans,
	input  wire logic                    hwrite,
	input  wire logic [2:0]              hsize,
	input  wire logic [31:0]             hwdata,
	input  wire logic                    hready,
	output logic                         hreadyout,
	output logic [31:0]                  hrdata,
	output logic                         hresp,
	// General-purpose pin directions
	output logic [PIN_COUNT-1:0]         pin_direction_bit,
	output logic [PIN_COUNT-1:0]         pin_output_enable,
	// Block power enables
	output logic                         digital_audio_transmitter_run,
	output logic [2:0]                   dac_power,
	output logic                         adc_path_power,
	output logic                         line_amp_one_power,
	// Upper analog input selector, decoded
	output logic                         upper_mute,
	output logic [LINE_COUNT-1:0]        upper_line,
	output logic                         upper_dac,
	// Lower analog input selector, decoded
	output logic                         lower_mute,
	output logic [LINE_COUNT-1:0]        lower_line,
	output logic                         lower_dac,
	// Transmitter channel status
	output logic                         copy_permit_flag,
	output logic                         emphasis_flag,
	output logic [1:0]                   clock_accuracy_field,
	output logic [3:0]                   word_length_field,
	output logic [1:0]                   sample_rate_field,
	output logic                         left_valid_flag,
	output logic                         right_valid_flag,
	output logic [3:0]                   source_channel_field,
	output logic [6:0]                   category_field,
	output logic                         generation_flag,
	output audio_cfg_pkg::output_route_e output_route
);

	// Word access path to the bus front end
	reg_access_if ra ();

	ahb_word_slave u_slave
	(
		.hclk      (hclk),
		.hresetn   (hresetn),
		.hsel      (hsel),
		.haddr     (haddr),
		.htrans    (htrans),
		.hwrite    (hwrite),
		.hsize     (hsize),
		.hwdata    (hwdata),
		.hready    (hready),
		.hreadyout (hreadyout),
		.hrdata    (hrdata),
		.hresp     (hresp),
		.ra        (ra.bus)
	);

	// Selector code to one-hot line, mute and DAC strobes
	function automatic audio_cfg_pkg::select_dec_s decode_select
	(
		input audio_cfg_pkg::select_code_t code
	);
		audio_cfg_pkg::select_dec_s d;
		d      = '0;
		d.mute = (code == `SEL_MUTE);
		d.dac  = (code == `SEL_DAC);
		for (int i = 0; i < LINE_COUNT; i++)
			d.line[i] = (code == 4'(i + 1));
		return d;
	endfunction

	// Reserved codes leave the selector unchanged
	// rather than parking the mux on an input that does not exist
	function automatic audio_cfg_pkg::select_code_t keep_legal
	(
		input audio_cfg_pkg::select_code_t now,
		input audio_cfg_pkg::select_code_t req
	);
		return (req >= `SEL_RSVD_FIRST) ? now : req;
	endfunction

	// Route bits to route enum; high bit wins over low bit
	function automatic audio_cfg_pkg::output_route_e decode_route
	(
		input logic [1:0] bits
	);
		audio_cfg_pkg::output_route_e r;
		if (bits[1])
			r = audio_cfg_pkg::route_passthrough;
		else if (bits[0])
			r = audio_cfg_pkg::route_transmitter;
		else
			r = audio_cfg_pkg::route_serial_two;
		return r;
	endfunction

	// Address hits
	// Index is a slave register, so the hits settle early in the cycle
	logic hit_dir;
	logic hit_pwr;
	logic hit_sel;
	logic hit_tx;
	assign hit_dir = (ra.index == `IDX_PIN_DIR);
	assign hit_pwr = (ra.index == `IDX_POWER);
	assign hit_sel = (ra.index == `IDX_ANALOG_SEL);
	assign hit_tx  = (ra.index == `IDX_TX_STATUS);

	logic wr_dir;
	logic wr_pwr;
	logic wr_sel;
	logic wr_tx;
	assign wr_dir = ra.wr_en & hit_dir;
	assign wr_pwr = ra.wr_en & hit_pwr;
	assign wr_sel = ra.wr_en & hit_sel;
	assign wr_tx  = ra.wr_en & hit_tx;

	// Stored selector codes
	audio_cfg_pkg::select_code_t sel_hi;
	audio_cfg_pkg::select_code_t sel_lo;
	audio_cfg_pkg::select_code_t next_sel_hi;
	audio_cfg_pkg::select_code_t next_sel_lo;
	audio_cfg_pkg::select_dec_s  dec_hi;
	audio_cfg_pkg::select_dec_s  dec_lo;

	assign next_sel_hi = wr_sel
		? keep_legal(sel_hi, ra.wdata[`SEL_HI_MSB:`SEL_HI_LSB]) : sel_hi;
	assign next_sel_lo = wr_sel
		? keep_legal(sel_lo, ra.wdata[`SEL_LO_MSB:`SEL_LO_LSB]) : sel_lo;
	assign dec_hi = decode_select(next_sel_hi);
	assign dec_lo = decode_select(next_sel_lo);

	logic [1:0] route_bits;
	logic [1:0] next_route_bits;
	assign next_route_bits = wr_tx
		? ra.wdata[`TX_ROUTE_MSB:`TX_ROUTE_LSB] : route_bits;

	// Pin directions
	// Only the direction bits of this word are stored here
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			pin_direction_bit <= {PIN_COUNT{1'b1}};
			pin_output_enable <= '0;
		end
		else if (wr_dir)
		begin
			pin_direction_bit <= ra.wdata[`DIR_LSB +: PIN_COUNT];
			pin_output_enable <= ~ra.wdata[`DIR_LSB +: PIN_COUNT];
		end
	end

	// Power enables; everything starts powered down
	// Bits 2 and 1 have no function, so nothing stores them
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			digital_audio_transmitter_run <= 1'b0;
			dac_power                     <= '0;
			adc_path_power                <= 1'b0;
			line_amp_one_power            <= 1'b0;
		end
		else if (wr_pwr)
		begin
			digital_audio_transmitter_run <= ra.wdata[`PWR_TX_BIT];
			dac_power[2]       <= ra.wdata[`PWR_DAC3_BIT];
			dac_power[1]       <= ra.wdata[`PWR_DAC2_BIT];
			dac_power[0]       <= ra.wdata[`PWR_DAC1_BIT];
			adc_path_power     <= ra.wdata[`PWR_ADC_BIT];
			line_amp_one_power <= ra.wdata[`PWR_AMP1_BIT];
		end
	end

	// Selectors: code and its decode are registered together
	// so the strobes never lag the read-back code by a cycle
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			sel_hi     <= `SEL_RESET;
			sel_lo     <= `SEL_RESET;
			upper_mute <= 1'b1;
			upper_line <= '0;
			upper_dac  <= 1'b0;
			lower_mute <= 1'b1;
			lower_line <= '0;
			lower_dac  <= 1'b0;
		end
		else
		begin
			sel_hi     <= next_sel_hi;
			sel_lo     <= next_sel_lo;
			upper_mute <= dec_hi.mute;
			upper_line <= dec_hi.line[LINE_COUNT-1:0];
			upper_dac  <= dec_hi.dac;
			lower_mute <= dec_lo.mute;
			lower_line <= dec_lo.line[LINE_COUNT-1:0];
			lower_dac  <= dec_lo.dac;
		end
	end

	// Channel status; reset announces 24-bit, 48 kHz, channel 2, DSP source
	// Fields are stored as written; coding them is the serializer's job
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			copy_permit_flag     <= 1'b0;
			emphasis_flag        <= 1'b0;
			clock_accuracy_field <= `TX_CLOCK_ACCURACY_FIELD_RESET;
			word_length_field    <= `TX_WLEN_24BIT;
			sample_rate_field    <= `TX_RATE_48K;
			left_valid_flag      <= 1'b0;
			right_valid_flag     <= 1'b0;
			source_channel_field <= `TX_SRC_RESET;
			category_field       <= `TX_CAT_RESET;
			generation_flag      <= 1'b0;
		end
		// word length code carried as written
		else if (wr_tx)
		begin
			copy_permit_flag     <= ra.wdata[`TX_COPY_BIT];
			emphasis_flag        <= ra.wdata[`TX_EMPH_BIT];
			clock_accuracy_field <=
				ra.wdata[`TX_CLOCK_ACCURACY_FIELD_MSB:`TX_CLOCK_ACCURACY_FIELD_LSB];
			word_length_field    <= ra.wdata[`TX_WLEN_MSB:`TX_WLEN_LSB];
			sample_rate_field    <= ra.wdata[`TX_RATE_MSB:`TX_RATE_LSB];
			left_valid_flag      <= ra.wdata[`TX_VLEFT_BIT];
			right_valid_flag     <= ra.wdata[`TX_VRIGHT_BIT];
			source_channel_field <= ra.wdata[`TX_SRC_MSB:`TX_SRC_LSB];
			category_field       <= ra.wdata[`TX_CAT_MSB:`TX_CAT_LSB];
			generation_flag      <= ra.wdata[`TX_GEN_BIT];
		end
	end

	// Route: raw bits kept for read-back, decoded enum drives the pin mux
	// Pass-through wins so code 10 still selects a defined source
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			route_bits   <= 2'h0;
			output_route <= audio_cfg_pkg::route_serial_two;
		end
		else
		begin
			route_bits   <= next_route_bits;
			output_route <= decode_route(next_route_bits);
		end
	end

	// Read-back words; unused bits stay zero
	// Reads wait a cycle in the slave, so a write just before is visible
	logic [31:0] rd_dir;
	logic [31:0] rd_pwr;
	logic [31:0] rd_sel;
	logic [31:0] rd_tx;

	always_comb
	begin
		rd_dir = '0;
		rd_dir[`DIR_LSB +: PIN_COUNT] = pin_direction_bit;
		rd_pwr = '0;
		rd_pwr[`PWR_TX_BIT]   = digital_audio_transmitter_run;
		rd_pwr[`PWR_DAC3_BIT] = dac_power[2];
		rd_pwr[`PWR_DAC2_BIT] = dac_power[1];
		rd_pwr[`PWR_DAC1_BIT] = dac_power[0];
		rd_pwr[`PWR_ADC_BIT]  = adc_path_power;
		rd_pwr[`PWR_AMP1_BIT] = line_amp_one_power;
		rd_sel = '0;
		rd_sel[`SEL_HI_MSB:`SEL_HI_LSB] = sel_hi;
		rd_sel[`SEL_LO_MSB:`SEL_LO_LSB] = sel_lo;
		rd_tx = '0;
		rd_tx[`TX_COPY_BIT]                = copy_permit_flag;
		rd_tx[`TX_EMPH_BIT]                = emphasis_flag;
		rd_tx[`TX_CLOCK_ACCURACY_FIELD_MSB:`TX_CLOCK_ACCURACY_FIELD_LSB] = clock_accuracy_field;
		rd_tx[`TX_WLEN_MSB:`TX_WLEN_LSB]   = word_length_field;
		rd_tx[`TX_RATE_MSB:`TX_RATE_LSB]   = sample_rate_field;
		rd_tx[`TX_VLEFT_BIT]               = left_valid_flag;
		rd_tx[`TX_VRIGHT_BIT]              = right_valid_flag;
		rd_tx[`TX_SRC_MSB:`TX_SRC_LSB]     = source_channel_field;
		rd_tx[`TX_CAT_MSB:`TX_CAT_LSB]     = category_field;
		rd_tx[`TX_GEN_BIT]                 = generation_flag;
		rd_tx[`TX_ROUTE_MSB:`TX_ROUTE_LSB] = route_bits;
	end

	// Unmapped indices read as zero
	assign ra.rdata = hit_dir ? rd_dir
		: hit_pwr ? rd_pwr
		: hit_sel ? rd_sel
		: hit_tx  ? rd_tx
		: `WORD_ZERO;

endmodule

// file: verification/audio_cfg_regs_props.sv
// Concurrent checks on the audio configuration bank's top-level ports.
// Assumes one clock domain and a single AHB-Lite master.
`timescale 1ns/1ps
`include "audio_cfg_map.svh"

module audio_cfg_regs_props
#(
	parameter int PIN_COUNT  = 2,
	parameter int LINE_COUNT = 10
)
(
	// Clock and reset
	input wire logic                         hclk,
	input wire logic                         hresetn,
	// AHB-Lite slave
	input wire logic                         hsel,
	input wire logic [31:0]                  haddr,
	input wire logic [1:0]                   htrans,
	input wire logic                         hwrite,
	input wire logic [2:0]                   hsize,
	input wire logic [31:0]                  hwdata,
	input wire logic                         hready,
	input wire logic                         hreadyout,
	input wire logic                         hresp,
	// Observed outputs
	input wire logic [PIN_COUNT-1:0]         pin_direction_bit,
	input wire logic [PIN_COUNT-1:0]         pin_output_enable,
	input wire logic [2:0]                   dac_power,
	input wire logic                         upper_mute,
	input wire logic [LINE_COUNT-1:0]        upper_line,
	input wire logic                         upper_dac,
	input wire logic                         copy_permit_flag,
	input wire logic                         emphasis_flag,
	input wire audio_cfg_pkg::output_route_e output_route
);
	localparam logic [31:0] A_PWR = {24'h0, `IDX_POWER, 2'h0};
	localparam logic [31:0] A_SEL = {24'h0, `IDX_ANALOG_SEL, 2'h0};
	localparam logic [31:0] A_TX  = {24'h0, `IDX_TX_STATUS, 2'h0};
	wire taken = hsel && htrans[1] && hready;
	wire wr_word = taken && hwrite && hsize == `HSIZE_WORD;

	default clocking dc @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	property p_read_wait;
		taken && !hwrite |=> !hreadyout ##1 hreadyout;
	endproperty
	a_read_wait: assert property (p_read_wait)
		else $error("read wait state wrong");
	property p_write_nowait;
		taken && hwrite |=> hreadyout;
	endproperty
	a_write_nowait: assert property (p_write_nowait)
		else $error("write stalled");
	property p_okay;
		hresp == 1'b0;
	endproperty
	a_okay: assert property (p_okay)
		else $error("response not okay");
	property p_pin_oe;
		pin_output_enable == ~pin_direction_bit;
	endproperty
	a_pin_oe: assert property (p_pin_oe)
		else $error("pin enable not inverse of direction");
	property p_upper_onehot;
		$onehot({upper_mute, upper_line, upper_dac});
	endproperty
	a_upper_onehot: assert property (p_upper_onehot)
		else $error("upper selector decode not one-hot");
	property p_route;
		output_route != 2'b10;
	endproperty
	a_route: assert property (p_route)
		else $error("illegal route");
	property p_power;
		wr_word && haddr == A_PWR |=> ##1 dac_power == $past(hwdata[6:4]);
	endproperty
	a_power: assert property (p_power)
		else $error("dac power not from written bits");
	property p_sel_hold;
		wr_word && haddr == A_SEL ##1 hwdata[27:26] == 2'b11
			|=> $stable({upper_mute, upper_line, upper_dac});
	endproperty
	a_sel_hold: assert property (p_sel_hold)
		else $error("reserved code changed selector");
	property p_status;
		wr_word && haddr == A_TX |=> ##1
			{copy_permit_flag, emphasis_flag} == $past(hwdata[31:30]);
	endproperty
	a_status: assert property (p_status)
		else $error("status flags not from written bits");
endmodule

bind audio_cfg_regs audio_cfg_regs_props
	#(.PIN_COUNT(PIN_COUNT), .LINE_COUNT(LINE_COUNT))
	audio_cfg_regs_props_inst
(
	.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
	.hready(hready), .hreadyout(hreadyout), .hresp(hresp),
	.pin_direction_bit(pin_direction_bit),
	.pin_output_enable(pin_output_enable), .dac_power(dac_power),
	.upper_mute(upper_mute), .upper_line(upper_line),
	.upper_dac(upper_dac), .copy_permit_flag(copy_permit_flag),
	.emphasis_flag(emphasis_flag), .output_route(output_route)
);

// file: verification/audio_cfg_regs_tb_top.sv
// Self-checking bench for the audio configuration register bank.
// Assumes the bank is the only slave: hready follows hreadyout.
`timescale 1ns/1ps
`include "audio_cfg_map.svh"

`define CHK(nm, e, g) \
	begin \
		n_compared++; \
		if ((e) !== (g)) \
		begin \
			num_errors++; \
			$display("MISMATCH %s exp %h got %h", nm, e, g); \
		end \
	end

module audio_cfg_regs_tb_top;
	localparam logic [31:0] A_PIN = {24'h0, `IDX_PIN_DIR, 2'h0};
	localparam logic [31:0] A_PWR = {24'h0, `IDX_POWER, 2'h0};
	localparam logic [31:0] A_SEL = {24'h0, `IDX_ANALOG_SEL, 2'h0};
	localparam logic [31:0] A_TX  = {24'h0, `IDX_TX_STATUS, 2'h0};
	localparam logic [2:0]  W     = `HSIZE_WORD;
	typedef struct packed
	{
		logic [31:0] data;
		logic [59:0] outs;
	} note_s;

	logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, rd_pend;
	logic [31:0] haddr, hwdata, hrdata, m_pwr, m_sel, m_tx, sd;
	logic [1:0]  htrans, m_dir, pin_direction_bit, pin_output_enable;
	logic [2:0]  hsize, dac_power;
	logic        digital_audio_transmitter_run, adc_path_power;
	logic        line_amp_one_power, upper_mute, upper_dac, lower_mute;
	logic        lower_dac, copy_permit_flag, emphasis_flag;
	logic        left_valid_flag, right_valid_flag, generation_flag;
	logic [9:0]  upper_line, lower_line;
	logic [1:0]  clock_accuracy_field, sample_rate_field;
	logic [3:0]  word_length_field, source_channel_field;
	logic [6:0]  category_field;
	int          num_errors, n_compared;
	note_s       exp_q[$];
	note_s       e;
	audio_cfg_pkg::output_route_e output_route;

	wire [59:0] got = {pin_direction_bit, pin_output_enable,
		digital_audio_transmitter_run, dac_power, adc_path_power,
		line_amp_one_power, upper_mute, upper_line, upper_dac, lower_mute,
		lower_line, lower_dac, copy_permit_flag, emphasis_flag,
		clock_accuracy_field, word_length_field, sample_rate_field,
		left_valid_flag, right_valid_flag, source_channel_field,
		category_field, generation_flag, output_route};

	audio_cfg_regs audio_cfg_regs_inst
	(
		.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready(hreadyout), .hreadyout, .hrdata, .hresp, .pin_direction_bit,
		.pin_output_enable, .digital_audio_transmitter_run, .dac_power,
		.adc_path_power, .line_amp_one_power, .upper_mute, .upper_line,
		.upper_dac, .lower_mute, .lower_line, .lower_dac, .copy_permit_flag,
		.emphasis_flag, .clock_accuracy_field, .word_length_field,
		.sample_rate_field, .left_valid_flag, .right_valid_flag,
		.source_channel_field, .category_field, .generation_flag,
		.output_route
	);

	function automatic logic [11:0] dec(input logic [3:0] c);
		// Codes 0 and 11 shift the one past the ten line bits
		dec = {c == `SEL_MUTE, 10'h001 << (c - 4'h1), c == `SEL_DAC};
	endfunction

	function automatic logic [59:0] snap();
		snap = {m_dir, ~m_dir, m_pwr[7:3], m_pwr[0], dec(m_sel[27:24]),
			dec(m_sel[3:0]), m_tx[31:8], m_tx[1], m_tx[1] | m_tx[0]};
	endfunction

	function automatic logic [31:0] rv(input logic [31:0] a);
		case (a)
			A_PIN: rv = {6'h0, m_dir, 24'h0};
			A_PWR: rv = m_pwr;
			A_SEL: rv = m_sel;
			A_TX: rv = m_tx;
			default: rv = 32'h0;
		endcase
	endfunction

	task automatic apply(input logic [31:0] a, d);
		case (a)
			A_PIN: m_dir = d[25:24];
			A_PWR: m_pwr = d & 32'h0000_00f9;
			A_SEL:
			begin
				// A reserved code leaves only its own selector alone
				if (d[27:24] < `SEL_RSVD_FIRST) m_sel[27:24] = d[27:24];
				if (d[3:0] < `SEL_RSVD_FIRST) m_sel[3:0] = d[3:0];
			end
			A_TX: m_tx = d & 32'hffff_ff03;
			default: ;
		endcase
	endtask

	task automatic wrap_up();
		$display("Compared %0d, mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic await();
		int n;
		n = 0;
		do
		begin
			@(posedge hclk);
			n++;
		end
		while (hreadyout !== 1'b1 && n < 20);
		if (hreadyout !== 1'b1)
		begin
			num_errors++;
			wrap_up();
		end
	endtask

	task automatic xfer(input logic w, input logic [31:0] a, d,
		input logic [2:0] sz);
		if (!w)
			exp_q.push_back({sz == W ? rv(a) : 32'h0, snap()});
		else if (sz == W)
			apply(a, d);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= `HTRANS_NONSEQ;
		hwrite <= w;
		hsize <= sz;
		await();
		htrans <= 2'h0;
		hwdata <= w ? d : $urandom;
		await();
	endtask

	initial
	begin
		hclk = 1'b0;
		forever #4 hclk = ~hclk;
	end

	always @(posedge hclk)
	begin
		if (rd_pend === 1'b1 && hreadyout === 1'b1)
		begin
			`CHK("queue", 1'b1, exp_q.size() != 0)
			e = exp_q.pop_front();
			`CHK("hrdata", e.data, hrdata)
			`CHK("pins", e.outs[59:56], got[59:56])
			`CHK("power", e.outs[55:50], got[55:50])
			`CHK("upper", e.outs[49:38], got[49:38])
			`CHK("lower", e.outs[37:26], got[37:26])
			`CHK("status", e.outs[25:2], got[25:2])
			`CHK("route", e.outs[1:0], got[1:0])
		end
		// A read stays pending through its wait state
		if (hreadyout === 1'b1)
			rd_pend = hresetn && hsel && htrans[1] && !hwrite;
	end

	initial
	begin
		{hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
		hsize = W;
		m_dir = 2'h3;
		m_pwr = 32'h0;
		m_sel = 32'h0;
		m_tx = 32'h0042_5400;
		void'($urandom(63423));
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		xfer(1'b0, A_PIN, 32'h0, W);
		xfer(1'b0, A_PWR, 32'h0, W);
		xfer(1'b0, A_SEL, 32'h0, W);
		xfer(1'b0, A_TX, 32'h0, W);
		xfer(1'b1, 32'h50, $urandom, W);
		xfer(1'b0, 32'h50, 32'h0, W);
		for (int i = 0; i < 4; i++)
		begin
			xfer(1'b1, A_PIN, $urandom & 32'hfcff_ffff | i << 24, W);
			xfer(1'b0, A_PIN, 32'h0, W);
		end
		for (int i = 0; i < 6; i++)
		begin
			xfer(1'b1, A_PWR, $urandom, W);
			xfer(1'b1, A_TX, $urandom, W);
			xfer(1'b0, A_PWR, 32'h0, W);
			xfer(1'b0, A_TX, 32'h0, W);
		end
		for (int c = 0; c < 16; c++)
		begin
			sd = $urandom & 32'hf0ff_fff0 | c << 24 | 15 - c;
			xfer(1'b1, A_SEL, sd, W);
			xfer(1'b0, A_SEL, 32'h0, W);
		end
		for (int r = 0; r < 4; r++)
		begin
			sd = $urandom & 32'h3fff_fffc | {r[1:0], 28'h0, r[1:0]};
			xfer(1'b1, A_TX, sd, W);
			xfer(1'b0, A_TX, 32'h0, W);
		end
		// Refused transfers must leave the power word alone
		xfer(1'b1, A_PWR, 32'hff, 3'h0);
		xfer(1'b1, A_PWR + 1, 32'hff, W);
		xfer(1'b1, A_PWR | 32'h100, 32'hff, W);
		xfer(1'b0, A_PWR, 32'h0, 3'h0);
		xfer(1'b0, A_PWR | 32'h100, 32'h0, W);
		xfer(1'b0, A_PWR, 32'h0, W);
		repeat (4) @(posedge hclk);
		`CHK("left", 1'b0, exp_q.size() != 0)
		wrap_up();
	end
endmodule
